// *** design/output_enable_consts.svh ***
/*
 * constants of the output-enable control block: register offsets, reset values,
 * writable masks, ID values and channel and pin counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef OUTPUT_ENABLE_CONSTS_SVH
`define OUTPUT_ENABLE_CONSTS_SVH

`define OEC_NUM_CHAN        20
`define OEC_NUM_PIN         8
`define OEC_PIN_BASE        5
`define OEC_ADDR_EN_HIGH    8'h00
`define OEC_ADDR_EN_LOW     8'h01
`define OEC_ADDR_EN_MID     8'h02
`define OEC_ADDR_PIN_RDBK   8'h03
`define OEC_ADDR_SEL_RDBK   8'h04
`define OEC_ADDR_VEND_REV   8'h05
`define OEC_ADDR_PART       8'h06
`define OEC_ADDR_RD_COUNT   8'h07
`define OEC_ADDR_OVR_1      8'h08
`define OEC_ADDR_OVR_2      8'h09
`define OEC_ADDR_OVR_3      8'h0A
`define OEC_RST_EN_HIGH     8'h78
`define OEC_RST_EN_LOW      8'hFF
`define OEC_RST_EN_MID      8'hFF
`define OEC_RST_RD_COUNT    8'h08
`define OEC_RST_OVR         8'h00
`define OEC_MASK_EN_HIGH    8'h78
`define OEC_MASK_RD_COUNT   8'h3F
`define OEC_MASK_OVR_3      8'h0F
`define OEC_RST_CHAN_EN     20'h00000
`define OEC_RST_SHIFT       20'h00000
`define OEC_VEND_REV_ID     8'h5A
`define OEC_PART_ID         8'hA5

`endif

// *** design/output_enable_pkg.sv ***
/*
 * types of the output-enable control block: the state records of both modules.
 * assumes output_enable_consts.svh is compiled alongside.
 */
package output_enable_pkg;

   // link-domain state
   typedef struct packed {
      logic [19:0] shift;
   } shifter_state_t;

   // reference-domain state
   typedef struct packed {
      logic        sel_s1;
      logic        sel_s2;
      logic [7:0]  oe_s1;
      logic [7:0]  oe_s2;
      logic        stb_s1;
      logic        stb_s2;
      logic        stb_d;
      logic [19:0] ck_s1;
      logic [19:0] ck_s2;
      logic [19:0] sb_out;
      logic [7:0]  en_high;
      logic [7:0]  en_low;
      logic [7:0]  en_mid;
      logic [7:0]  rd_count;
      logic [7:0]  ovr_1;
      logic [7:0]  ovr_2;
      logic [7:0]  ovr_3;
      logic [7:0]  rdata;
      logic [19:0] chan_en;
   } oec_state_t;

endpackage

// *** design/sideband_shifter.sv ***
/*
 * side-band serial port shift register, clocked by the host's serial clock.
 * assumes the host holds data and strobe steady around each rising clock edge
 * and stops the clock while the strobe is low.
 */
`timescale 1ns/1ps
`include "output_enable_consts.svh"

module sideband_shifter (
   input  wire logic        i_sb_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_sb_data,
   input  wire logic        i_shift_load_strobe_n,
   output logic [19:0]      o_shift_word,
   output logic             o_sb_data_out
);

   output_enable_pkg::shifter_state_t state_reg;
   output_enable_pkg::shifter_state_t state_next;

   // shift in at bit 0 while the strobe is high
   always_comb begin
      state_next = state_reg;
      if (i_shift_load_strobe_n) begin
         state_next.shift = {state_reg.shift[18:0], i_sb_data}; // R1
      end
   end

   // state register
   always_ff @(posedge i_sb_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg.shift <= `OEC_RST_SHIFT;
      end else begin
         state_reg <= state_next;
      end
   end

   // word held still once the strobe falls; msb feeds the next chained buffer
   assign o_shift_word  = state_reg.shift; // R12
   assign o_sb_data_out = state_reg.shift[19]; // R4

endmodule // sideband_shifter

// *** design/output_enable_control.sv ***
/*
 * output-enable control of a 20-output clock buffer: side-band serial port,
 * byte-wide register map and shared glitch-free enable logic.
 * assumes a register engine on i_ref_clk presents address, write strobe and
 * data, and that each channel clock level is visible on i_chan_clk.
 */
// Function
// R1 - while the strobe is high each rising serial clock edge shifts the data line in.
// R2 - the falling strobe copies the whole shift register into the side-band output register.
// R3 - side-band and register requests pass one shared enable synchronisation stage.
// R4 - the host may wire the port as star, daisy chain or direct link.
// R5 - the host leaves offsets outside the map unwritten.
// R6 - offset 0h resets to 78h, bits 6..3 enable channels 19..16, other bits read zero.
// R7 - offset 1h resets to FFh, bit n enables channel n.
// R8 - an enable bit of 0 disables its output and 1 enables it.
// R9 - offsets 3h and 4h read back the enable pins and the side-band select pin.
// R10 - offset 7h sets how many bytes a block read returns.
// R11 - offsets 8h, 9h and Ah mask the side-band bits per channel.
// R12 - shift register and side-band output register are 20 bits, one per channel.
// R13 - select high gives control to the side-band port, low to registers and pins.
// R14 - in register mode a pinned channel runs only with its bit set and its pin low.
// R15 - in side-band mode the override masks force channels enabled.
// R16 - a new enable takes effect only while that channel's clock is low.
`timescale 1ns/1ps
`include "output_enable_consts.svh"

module output_enable_control (
   input  wire logic        i_ref_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_sb_clk,
   input  wire logic        i_sb_data,
   input  wire logic        i_shift_load_strobe_n,
   output logic             o_sb_data_out,
   input  wire logic        i_sideband_select_pin,
   input  wire logic [7:0]  i_oe_n,
   input  wire logic [19:0] i_chan_clk,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_wdata,
   output logic [7:0]       o_reg_rdata,
   output logic [5:0]       o_read_byte_count,
   output logic             o_sideband_active,
   output logic [19:0]      o_chan_en
);

   output_enable_pkg::oec_state_t state_reg;
   output_enable_pkg::oec_state_t state_next;

   logic [19:0] shift_word;
   logic [19:0] reg_en;
   logic [19:0] ovr_en;
   logic [19:0] want_en;

   // link-domain shifter
   sideband_shifter u_shifter (
      .i_sb_clk              (i_sb_clk),
      .i_nrst                (i_nrst),
      .i_sb_data             (i_sb_data),
      .i_shift_load_strobe_n (i_shift_load_strobe_n),
      .o_shift_word          (shift_word),
      .o_sb_data_out         (o_sb_data_out)
   );

   // register read decode
   function automatic logic [7:0] reg_read(
      input logic [7:0]                    addr,
      input output_enable_pkg::oec_state_t s
   );
      logic [7:0] d;
      d = 8'h00;
      if (addr == `OEC_ADDR_EN_HIGH) begin
         d = s.en_high & `OEC_MASK_EN_HIGH; // R6
      end else if (addr == `OEC_ADDR_EN_LOW) begin
         d = s.en_low; // R7
      end else if (addr == `OEC_ADDR_EN_MID) begin
         d = s.en_mid;
      end else if (addr == `OEC_ADDR_PIN_RDBK) begin
         d = s.oe_s2; // R9
      end else if (addr == `OEC_ADDR_SEL_RDBK) begin
         d = {7'h00, s.sel_s2}; // R9
      end else if (addr == `OEC_ADDR_VEND_REV) begin
         d = `OEC_VEND_REV_ID; // arbitrary value
      end else if (addr == `OEC_ADDR_PART) begin
         d = `OEC_PART_ID; // arbitrary value
      end else if (addr == `OEC_ADDR_RD_COUNT) begin
         d = s.rd_count & `OEC_MASK_RD_COUNT; // R10
      end else if (addr == `OEC_ADDR_OVR_1) begin
         d = s.ovr_1; // R11
      end else if (addr == `OEC_ADDR_OVR_2) begin
         d = s.ovr_2; // R11
      end else if (addr == `OEC_ADDR_OVR_3) begin
         d = s.ovr_3 & `OEC_MASK_OVR_3; // R11
      end
      return d;
   endfunction

   // per-channel register enables and override masks
   assign reg_en = {state_reg.en_high[6:3], state_reg.en_mid, state_reg.en_low}; // R6
   assign ovr_en = {state_reg.ovr_3[3:0], state_reg.ovr_2, state_reg.ovr_1}; // R11

   // requested enable per channel, whichever path is selected
   genvar n;
   generate
      for (n = 0; n < `OEC_NUM_CHAN; n = n + 1) begin : g_want
         if (n >= `OEC_PIN_BASE && n < `OEC_PIN_BASE + `OEC_NUM_PIN) begin : g_pin
            assign want_en[n] = state_reg.sel_s2 ?
                                (state_reg.sb_out[n] | ovr_en[n]) : // R15
                                (reg_en[n] & ~state_reg.oe_s2[n - `OEC_PIN_BASE]); // R14
         end else begin : g_nopin
            assign want_en[n] = state_reg.sel_s2 ?
                                (state_reg.sb_out[n] | ovr_en[n]) : // R15
                                reg_en[n]; // R8
         end
      end
   endgenerate

   // next-state logic
   always_comb begin
      state_next = state_reg;

      // pin synchronisers, two stages each
      state_next.sel_s1 = i_sideband_select_pin;
      state_next.sel_s2 = state_reg.sel_s1; // R13
      state_next.oe_s1  = i_oe_n;
      state_next.oe_s2  = state_reg.oe_s1;
      state_next.stb_s1 = i_shift_load_strobe_n;
      state_next.stb_s2 = state_reg.stb_s1;
      state_next.stb_d  = state_reg.stb_s2;
      state_next.ck_s1  = i_chan_clk;
      state_next.ck_s2  = state_reg.ck_s1;

      // falling strobe: shift word is frozen, copy it across
      if (state_reg.stb_d && !state_reg.stb_s2) begin
         state_next.sb_out = shift_word; // R2
      end

      // register writes; unmapped offsets are ignored
      if (i_reg_wr) begin
         if (i_reg_addr == `OEC_ADDR_EN_HIGH) begin
            state_next.en_high = i_reg_wdata & `OEC_MASK_EN_HIGH; // R6
         end else if (i_reg_addr == `OEC_ADDR_EN_LOW) begin
            state_next.en_low = i_reg_wdata; // R7
         end else if (i_reg_addr == `OEC_ADDR_EN_MID) begin
            state_next.en_mid = i_reg_wdata;
         end else if (i_reg_addr == `OEC_ADDR_RD_COUNT) begin
            state_next.rd_count = i_reg_wdata & `OEC_MASK_RD_COUNT; // R10
         end else if (i_reg_addr == `OEC_ADDR_OVR_1) begin
            state_next.ovr_1 = i_reg_wdata; // R11
         end else if (i_reg_addr == `OEC_ADDR_OVR_2) begin
            state_next.ovr_2 = i_reg_wdata; // R11
         end else if (i_reg_addr == `OEC_ADDR_OVR_3) begin
            state_next.ovr_3 = i_reg_wdata & `OEC_MASK_OVR_3; // R11
         end
      end

      // registered read data
      state_next.rdata = reg_read(i_reg_addr, state_reg);

      // shared update stage: each channel changes only while its clock is low
      for (int i = 0; i < `OEC_NUM_CHAN; i++) begin
         if (!state_reg.ck_s2[i]) begin
            state_next.chan_en[i] = want_en[i]; // R3 R16
         end
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg.sel_s1   <= 1'b0;
         state_reg.sel_s2   <= 1'b0;
         state_reg.oe_s1    <= 8'h00;
         state_reg.oe_s2    <= 8'h00;
         state_reg.stb_s1   <= 1'b0;
         state_reg.stb_s2   <= 1'b0;
         state_reg.stb_d    <= 1'b0;
         state_reg.ck_s1    <= 20'h00000;
         state_reg.ck_s2    <= 20'h00000;
         state_reg.sb_out   <= `OEC_RST_SHIFT;
         state_reg.en_high  <= `OEC_RST_EN_HIGH; // R6
         state_reg.en_low   <= `OEC_RST_EN_LOW; // R7
         state_reg.en_mid   <= `OEC_RST_EN_MID;
         state_reg.rd_count <= `OEC_RST_RD_COUNT;
         state_reg.ovr_1    <= `OEC_RST_OVR;
         state_reg.ovr_2    <= `OEC_RST_OVR;
         state_reg.ovr_3    <= `OEC_RST_OVR;
         state_reg.rdata    <= 8'h00;
         state_reg.chan_en  <= `OEC_RST_CHAN_EN;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs, all from flip-flops
   assign o_reg_rdata       = state_reg.rdata;
   assign o_read_byte_count = state_reg.rd_count[5:0]; // R10
   assign o_sideband_active = state_reg.sel_s2; // R13
   assign o_chan_en         = state_reg.chan_en; // R8

endmodule // output_enable_control

// *** bench/oec_host_model.sv ***
/* side-band host model: serial clock, data line and shift/load strobe.
   assumes the bench calls send_word while the device is in side-band mode. */
`timescale 1ns/1ps
module oec_host_model (
   output logic o_sb_clk,
   output logic o_sb_data,
   output logic o_shift_load_strobe_n
);
   // idle: clock still, strobe low
   initial begin
      o_sb_clk = 1'b0;
      o_sb_data = 1'b0;
      o_shift_load_strobe_n = 1'b0;
   end
   // one direct-link frame, channel 19 first, then load
   task send_word(input logic [19:0] w);
      o_shift_load_strobe_n = 1'b1;
      #32;
      for (int i = 19; i >= 0; i--) begin
         o_sb_data = w[i];
         #16 o_sb_clk = 1'b1;
         #16 o_sb_clk = 1'b0;
      end
      #16 o_shift_load_strobe_n = 1'b0;
      o_sb_data = ~o_sb_data;
      #48;
   endtask
endmodule // oec_host_model

// *** bench/output_enable_control_sva.sv ***
/* port assertions of the output-enable control block.
   assumes one reference clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module output_enable_control_sva (
   input wire logic        i_ref_clk,
   input wire logic        i_nrst,
   input wire logic [7:0]  i_oe_n,
   input wire logic [19:0] i_chan_clk,
   input wire logic        i_sideband_select_pin,
   input wire logic [7:0]  i_reg_addr,
   input wire logic        i_reg_wr,
   input wire logic [7:0]  i_reg_wdata,
   input wire logic [7:0]  o_reg_rdata,
   input wire logic [5:0]  o_read_byte_count,
   input wire logic        o_sideband_active,
   input wire logic [19:0] o_chan_en
);
   // all checks on the reference clock
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);
   property p_rsvd;
      i_reg_addr == 8'h00 |=> (o_reg_rdata & 8'h87) == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_low;
      i_reg_wr && i_reg_addr == 8'h01 ##1 !i_reg_wr && i_reg_addr == 8'h01
         |=> o_reg_rdata == $past(i_reg_wdata, 2);
   endproperty
   a_low: assert property (p_low) else $error("low enables lost");
   property p_cnt;
      i_reg_wr && i_reg_addr == 8'h07 |=> {2'b00, o_read_byte_count} == ($past(i_reg_wdata) & 8'h3F);
   endproperty
   a_cnt: assert property (p_cnt) else $error("byte count wrong");
   property p_ovr;
      i_reg_addr == 8'h0A |=> o_reg_rdata[7:4] == 4'h0;
   endproperty
   a_ovr: assert property (p_ovr) else $error("override bits set");
   property p_sel;
      $rose(i_sideband_select_pin) |-> ##[1:4] o_sideband_active;
   endproperty
   a_sel: assert property (p_sel) else $error("select not followed");
   property p_pin;
      (!o_sideband_active && i_oe_n[0] && !i_chan_clk[5])[*5] |-> !o_chan_en[5];
   endproperty
   a_pin: assert property (p_pin) else $error("pin did not gate");
   property p_glitch;
      ((o_chan_en ^ $past(o_chan_en)) & $past(i_chan_clk, 2) & $past(i_chan_clk, 3)
         & $past(i_chan_clk, 4)) == 20'h00000;
   endproperty
   a_glitch: assert property (p_glitch) else $error("enable changed, clock high");
   property p_off;
      i_reg_wr && i_reg_addr == 8'h01 && !i_reg_wdata[0] && !o_sideband_active
         && !i_chan_clk[0] |-> ##[2:5] !o_chan_en[0];
   endproperty
   a_off: assert property (p_off) else $error("zero bit left output on");
endmodule // output_enable_control_sva

bind output_enable_control output_enable_control_sva u_sva (
   .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_oe_n(i_oe_n), .i_chan_clk(i_chan_clk),
   .i_sideband_select_pin(i_sideband_select_pin), .i_reg_addr(i_reg_addr),
   .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .o_read_byte_count(o_read_byte_count), .o_sideband_active(o_sideband_active),
   .o_chan_en(o_chan_en));

// *** bench/tb_top.sv ***
/* self-checking bench of the output-enable control block.
   assumes design, host model and checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk, nrst, sb_clk, sb_data, stb_n, sel, wr, sb_dout, sb_act;
   logic [7:0]  oe_n, addr, wdata, rdata;
   logic [19:0] ck, chan_en;
   logic [5:0]  cnt;
   int          bad_count, comparisons;
   // reference clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   oec_host_model u_host (.o_sb_clk(sb_clk), .o_sb_data(sb_data), .o_shift_load_strobe_n(stb_n));
   output_enable_control u_dut (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_sb_clk(sb_clk),
      .i_sb_data(sb_data), .i_shift_load_strobe_n(stb_n), .o_sb_data_out(sb_dout),
      .i_sideband_select_pin(sel), .i_oe_n(oe_n), .i_chan_clk(ck), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_read_byte_count(cnt),
      .o_sideband_active(sb_act), .o_chan_en(chan_en));
   // compare and count
   task check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // register access: write strobe for one edge, read two edges later
   task wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(negedge ref_clk);
      wr = 1'b0;
   endtask
   task rd_reg(input logic [7:0] a);
      @(negedge ref_clk);
      addr = a;
      repeat (2) @(negedge ref_clk);
   endtask
   // reset value, write, read back at every offset of the map but 5h and 6h, and beyond it
   task automatic t_registers;
      logic [7:0] a [10] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h03, 8'h04, 8'h20};
      logic [7:0] r [10] = '{8'h78, 8'hFF, 8'hFF, 8'h08, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h00, 8'h00};
      logic [7:0] v [10] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h02, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF};
      logic [7:0] e [10] = '{8'h78, 8'h00, 8'hFF, 8'h3F, 8'h02, 8'h00, 8'h0F, 8'hA5, 8'h00, 8'h00};
      oe_n = 8'hA5;
      for (int i = 0; i < 10; i++) begin
         rd_reg(a[i]);
         check("reset value", {12'h000, rdata}, {12'h000, r[i]});
         // offsets outside the map are only read, never written
         if (a[i] <= 8'h0A) begin
            wr_reg(a[i], v[i]);
         end
         rd_reg(a[i]);
         check("written value", {12'h000, rdata}, {12'h000, e[i]});
      end
      check("byte count", {14'h0000, cnt}, 20'h0003F);
      oe_n = 8'h00;
      $display("test registers done");
   endtask
   // register mode with enable pins
   task t_register_mode;
      repeat (6) @(negedge ref_clk);
      check("register enables", chan_en, 20'hFFF00);
      oe_n = 8'h01;
      wr_reg(8'h01, 8'hFF);
      repeat (6) @(negedge ref_clk);
      check("pin gated", chan_en, 20'hFFFDF);
      oe_n = 8'h00;
      $display("test register_mode done");
   endtask
   // side-band load, override and clock-low update
   task t_sideband;
      wr_reg(8'h0A, 8'h00);
      sel = 1'b1;
      repeat (6) @(negedge ref_clk);
      check("side-band active", {19'h00000, sb_act}, 20'h00001);
      rd_reg(8'h04);
      check("select readback", {12'h000, rdata}, 20'h00001);
      u_host.send_word(20'h5A3C1);
      repeat (8) @(negedge ref_clk);
      check("loaded enables", chan_en, 20'h5A3C3);
      check("chain out, first frame", {19'h00000, sb_dout}, 20'h00000);
      ck = 20'hFFFFF;
      u_host.send_word(20'h80000);
      repeat (8) @(negedge ref_clk);
      check("held, clock high", chan_en, 20'h5A3C3);
      check("chain out, second frame", {19'h00000, sb_dout}, 20'h00001);
      ck = 20'h00000;
      repeat (6) @(negedge ref_clk);
      check("updated, clock low", chan_en, 20'h80002);
      sel = 1'b0;
      $display("test sideband done");
   endtask
   // counts and verdict
   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // main sequence
   initial begin
      nrst = 1'b0;
      sel = 1'b0;
      oe_n = 8'h00;
      ck = 20'h00000;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      t_registers();
      t_register_mode();
      t_sideband();
      conclude();
   end
   // watchdog against a hung run
   initial begin
      #100000;
      bad_count++;
      conclude();
   end
endmodule // tb_top
